// file: rtl/hbp_top.sv
/*
 * Mode and PWM control of a ten half-bridge driver: wake, logic and load
 * supply monitoring, register bank, three PWM channels, bridge drive with
 * selectable freewheeling, event status with mask and interrupt.
 * Assumes a register master on the same clock, wake and supply-good levels
 * from pins, and power stages that treat hs and ls both low as high-Z.
 */
`timescale 1ns/10ps
module hbp_top (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // pins
    input wire logic i_wake,
    input wire logic i_vdd_good,
    input wire logic i_vs_good,
    // power stage drive
    output logic [9:0] o_hs_on,
    output logic [9:0] o_ls_on,
    output logic o_pump_on,
    // interrupt
    output logic o_irq
);

    typedef struct packed {
        logic [2:0] wake_s;
        logic [2:0] vdd_s;
        logic [2:0] vs_s;
        logic wake_f;
        logic vdd_f;
        logic vs_f;
        logic [9:0] act_hs;
        logic [9:0] act_ls;
        logic [19:0] asg;
        logic [5:0] freq;
        logic [23:0] duty;
        logic [9:0] fw;
        logic pwr_loss;
        logic [4:0] irq_st;
        logic [4:0] irq_mask;
        logic [31:0] rdata;
        logic [9:0] hs;
        logic [9:0] ls;
        logic pump;
    } hbp_top_st_t;

    hbp_top_st_t r;
    hbp_top_st_t n;

    logic normal;
    logic ch_clr;
    logic [2:0] ch_main;
    logic [2:0] ch_comp;
    logic [2:0] ch_fwok;
    logic [2:0] ch_start;
    logic [2:0] ch_run;

    // filtered wake and logic supply together decide normal mode
    assign normal = r.wake_f && r.vdd_f;
    // channels are cleared with the register banks whenever not in normal mode
    assign ch_clr = i_rst || !normal;

    ////////////////////////////////////////////////////////////////////////
    // three channels, each with its own frequency code and duty
    for (genvar c = 0; c < 3; c++) begin : g_chan
        hbp_pwm_chan u_chan (
            .i_clk_sys(i_clk_sys),
            .i_rst(ch_clr),
            .i_freq(r.freq[2*c +: 2]),
            .i_duty(r.duty[8*c +: 8]),
            .o_main(ch_main[c]),
            .o_comp(ch_comp[c]),
            .o_fw_ok(ch_fwok[c]),
            .o_period_start(ch_start[c]),
            .o_running(ch_run[c])
        );
    end

    // pin filter: a new level counts once the second and third stage agree
    function automatic logic hbp_filt(input logic [2:0] s, input logic cur);
        hbp_filt = (s[1] == s[2]) ? s[2] : cur;
    endfunction : hbp_filt

    ////////////////////////////////////////////////////////////////////////
    // next state: pins, register bank, events, bridge drive
    always_comb begin
        logic [4:0] ev;
        logic [4:0] clr;
        logic [1:0] sel;
        logic [1:0] ci;
        logic hs_b;
        logic ls_b;
        n = r;
        ev = 5'h00;
        clr = 5'h00;
        sel = 2'h0;
        ci = 2'h0;
        hs_b = 1'b0;
        ls_b = 1'b0;

        // synchronisers; stage 0 only feeds stage 1
        n.wake_s = {r.wake_s[1:0], i_wake};
        n.vdd_s = {r.vdd_s[1:0], i_vdd_good};
        n.vs_s = {r.vs_s[1:0], i_vs_good};
        n.wake_f = hbp_filt(r.wake_s, r.wake_f);
        n.vdd_f = hbp_filt(r.vdd_s, r.vdd_f);
        n.vs_f = hbp_filt(r.vs_s, r.vs_f);

        // register reads; a dead logic supply answers zero
        n.rdata = 32'h00000000;
        if (i_rd && normal) begin
            if (i_addr == hbp_pkg::OFS_ACT_HS) begin
                n.rdata = {22'h000000, r.act_hs};
            end else if (i_addr == hbp_pkg::OFS_ACT_LS) begin
                n.rdata = {22'h000000, r.act_ls};
            end else if (i_addr == hbp_pkg::OFS_ASSIGN) begin
                n.rdata = {12'h000, r.asg};
            end else if (i_addr == hbp_pkg::OFS_FREQ) begin
                n.rdata = {26'h0000000, r.freq};
            end else if (i_addr == hbp_pkg::OFS_DUTY) begin
                n.rdata = {8'h00, r.duty};
            end else if (i_addr == hbp_pkg::OFS_FW) begin
                n.rdata = {22'h000000, r.fw};
            end else if (i_addr == hbp_pkg::OFS_STATUS) begin
                n.rdata[hbp_pkg::STAT_PWR_LOSS_BIT] = r.pwr_loss;
                n.rdata[hbp_pkg::STAT_VS_BIT] = r.vs_f;
                n.rdata[hbp_pkg::STAT_NORMAL_BIT] = normal;
            end else if (i_addr == hbp_pkg::OFS_IRQ_ST) begin
                n.rdata = {27'h0000000, r.irq_st};
                clr = r.irq_st; // read clears what it returned
            end else if (i_addr == hbp_pkg::OFS_IRQ_MASK) begin
                n.rdata = {27'h0000000, r.irq_mask};
            end
        end

        // register writes; stored data survives a load supply dropout
        if (i_wr && normal) begin
            if (i_addr == hbp_pkg::OFS_ACT_HS) begin
                n.act_hs = i_wdata[9:0];
            end else if (i_addr == hbp_pkg::OFS_ACT_LS) begin
                n.act_ls = i_wdata[9:0];
            end else if (i_addr == hbp_pkg::OFS_ASSIGN) begin
                n.asg = i_wdata[19:0];
            end else if (i_addr == hbp_pkg::OFS_FREQ) begin
                n.freq = i_wdata[5:0];
            end else if (i_addr == hbp_pkg::OFS_DUTY) begin
                n.duty = i_wdata[23:0]; // applied by channels at boundary
            end else if (i_addr == hbp_pkg::OFS_FW) begin
                n.fw = i_wdata[9:0];
            end else if (i_addr == hbp_pkg::OFS_STATUS) begin
                n.pwr_loss = i_wdata[hbp_pkg::STAT_PWR_LOSS_BIT];
            end else if (i_addr == hbp_pkg::OFS_IRQ_MASK) begin
                n.irq_mask = i_wdata[4:0];
            end
        end

        // sticky events; a new event beats a read clear in the same cycle
        ev[hbp_pkg::IRQ_PERIOD_LSB +: 3] = ch_start;
        ev[hbp_pkg::IRQ_VS_DROP_BIT] = r.vs_f && !n.vs_f;
        ev[hbp_pkg::IRQ_VS_BACK_BIT] = !r.vs_f && n.vs_f;
        n.irq_st = (r.irq_st & ~clr) | ev;

        // bridge drive; the registered outputs never switch both sides on
        for (int b = 0; b < 10; b++) begin
            sel = r.asg[2*b +: 2];
            ci = sel - 2'h1;
            hs_b = 1'b0;
            ls_b = 1'b0;
            if (sel == 2'h0) begin
                hs_b = r.act_hs[b]; // continuous drive
                ls_b = r.act_ls[b] && !r.act_hs[b];
            end else if (r.act_hs[b]) begin
                if (ch_run[ci]) begin
                    hs_b = ch_main[ci];
                    ls_b = r.fw[b] && ch_fwok[ci] && ch_comp[ci];
                end else begin
                    ls_b = r.fw[b];
                end
            end else if (r.act_ls[b]) begin
                if (ch_run[ci]) begin
                    ls_b = ch_main[ci];
                    hs_b = r.fw[b] && ch_fwok[ci] && ch_comp[ci];
                end
            end
            // a load supply dropout only gates the stages, not the settings
            n.hs[b] = hs_b && normal && r.vs_f;
            n.ls[b] = ls_b && normal && r.vs_f;
        end
        n.pump = normal;

        // sleep or dead logic supply: banks back to reset values
        if (!normal) begin
            n.act_hs = hbp_pkg::ACT_RST;
            n.act_ls = hbp_pkg::ACT_RST;
            n.asg = hbp_pkg::ASSIGN_RST;
            n.freq = hbp_pkg::FREQ_RST;
            n.duty = hbp_pkg::DUTY_RST;
            n.fw = hbp_pkg::FW_RST; // passive after reset
            n.pwr_loss = 1'b0;
            n.irq_st = 5'h00;
            n.irq_mask = hbp_pkg::IRQ_MASK_RST;
        end
    end

    // state register; reset clears everything and leaves the stages high-Z
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_rdata = r.rdata;
    assign o_hs_on = r.hs;
    assign o_ls_on = r.ls;
    assign o_pump_on = r.pump;
    // level interrupt while any unmasked sticky bit is set
    assign o_irq = |(r.irq_st & r.irq_mask);

    ////////////////////////////////////////////////////////////////////////
    // checks
    por_highz_a: assert property (@(posedge i_clk_sys)
        i_rst |=> (o_hs_on == 10'h000 && o_ls_on == 10'h000 && o_rdata == 32'h00000000))
        else $error("outputs not off after power-on reset");

    vs_keeps_cfg_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (normal && !r.vs_f && !i_wr) |=> ($stable(r.act_hs) && $stable(r.fw) && o_hs_on == 10'h000))
        else $error("load supply dropout disturbed settings");

    wake_pump_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        normal |=> o_pump_on)
        else $error("charge pump off in normal mode");

    sleep_clears_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !normal |=> (r.act_hs == 10'h000 && r.freq == 6'h00 && o_hs_on == 10'h000 && o_ls_on == 10'h000))
        else $error("sleep left banks or outputs set");

    vdd_bus_dead_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (!r.vdd_f && i_rd) |=> (o_rdata == 32'h00000000))
        else $error("bus answered with logic supply low");

    sequence wake_back_read_s;
        !normal ##1 (normal && !i_wr) [*2] ##0 (i_rd && i_addr == hbp_pkg::OFS_STATUS);
    endsequence

    pwr_loss_zero_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        wake_back_read_s |=> (o_rdata[hbp_pkg::STAT_PWR_LOSS_BIT] == 1'b0))
        else $error("power loss indicator not zero after reset");

    passive_default_a: assert property (@(posedge i_clk_sys)
        i_rst |=> (r.fw == 10'h000))
        else $error("freewheel not passive after reset");

    no_shoot_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (o_hs_on & o_ls_on) == 10'h000)
        else $error("both switches of a bridge on");

    for (genvar b = 0; b < 10; b++) begin : g_chk
        stopped_fw_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
            (normal && r.vs_f && r.act_hs[b] && r.asg[2*b +: 2] != 2'h0 && r.fw[b]
                && !ch_run[r.asg[2*b +: 2] - 2'h1]) |=> (o_ls_on[b] && !o_hs_on[b]))
            else $error("stopped active freewheel did not move to low side");
    end

endmodule : hbp_top

// file: shared/hbp_pkg.sv
/*
 * Constants shared by the half-bridge mode and PWM control block: register
 * offsets, field layouts, reset values, frequency codes and timing counts.
 * Assumes a 25 MHz system clock and a plain register port with 8-bit byte
 * addresses and 32-bit data.
 */
package hbp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // geometry
    localparam int unsigned NUM_BR = 10;
    localparam int unsigned NUM_CH = 3;
    localparam int unsigned DUTY_STEPS = 256;

    ////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned CLK_NS = 40;
    localparam int unsigned FREQ_A_HZ = 80;
    localparam int unsigned FREQ_B_HZ = 100;
    localparam int unsigned FREQ_C_HZ = 200;
    // one duty step in clock cycles; the period is this times 256
    localparam logic [10:0] STEP_A_CYC = 11'(CLK_HZ / (FREQ_A_HZ * DUTY_STEPS));
    localparam logic [10:0] STEP_B_CYC = 11'(CLK_HZ / (FREQ_B_HZ * DUTY_STEPS));
    localparam logic [10:0] STEP_C_CYC = 11'(CLK_HZ / (FREQ_C_HZ * DUTY_STEPS));
    // cross-conduction delays, least times, so rounded up
    localparam int unsigned DEAD_HL_NS = 500;
    localparam int unsigned DEAD_LH_NS = 500;
    localparam logic [18:0] DEAD_HL_CYC = 19'((DEAD_HL_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [18:0] DEAD_LH_CYC = 19'((DEAD_LH_NS + CLK_NS - 1) / CLK_NS);

    ////////////////////////////////////////////////////////////////////////
    // channel frequency codes
    localparam logic [1:0] FREQ_STOP = 2'h0;
    localparam logic [1:0] FREQ_80 = 2'h1;
    localparam logic [1:0] FREQ_100 = 2'h2;
    localparam logic [1:0] FREQ_200 = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] OFS_ACT_HS = 8'h00;
    localparam logic [7:0] OFS_ACT_LS = 8'h04;
    localparam logic [7:0] OFS_ASSIGN = 8'h08;
    localparam logic [7:0] OFS_FREQ = 8'h0C;
    localparam logic [7:0] OFS_DUTY = 8'h10;
    localparam logic [7:0] OFS_FW = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_IRQ_ST = 8'h1C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

    ////////////////////////////////////////////////////////////////////////
    // field positions and reset values
    localparam int unsigned STAT_PWR_LOSS_BIT = 0;
    localparam int unsigned STAT_VS_BIT = 1;
    localparam int unsigned STAT_NORMAL_BIT = 2;
    localparam int unsigned IRQ_W = 5;
    localparam int unsigned IRQ_PERIOD_LSB = 0;
    localparam int unsigned IRQ_VS_DROP_BIT = 3;
    localparam int unsigned IRQ_VS_BACK_BIT = 4;
    localparam logic [9:0] ACT_RST = 10'h000;
    localparam logic [19:0] ASSIGN_RST = 20'h00000;
    localparam logic [5:0] FREQ_RST = 6'h00;
    localparam logic [23:0] DUTY_RST = 24'h000000;
    localparam logic [9:0] FW_RST = 10'h000;
    localparam logic [4:0] IRQ_MASK_RST = 5'h00;

endpackage : hbp_pkg

// file: rtl/hbp_pwm_chan.sv
/*
 * One PWM channel: period counter, shadowed frequency and duty, main and
 * dead-banded complementary waveforms.
 * Assumes its inputs come from registers on the same clock and that i_rst
 * is held while the block sleeps.
 */
`timescale 1ns/10ps
module hbp_pwm_chan (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // settings from the register bank
    input wire logic [1:0] i_freq,
    input wire logic [7:0] i_duty,
    // waveforms and status
    output logic o_main,
    output logic o_comp,
    output logic o_fw_ok,
    output logic o_period_start,
    output logic o_running
);

    typedef struct packed {
        logic [1:0] code;
        logic [7:0] duty;
        logic [10:0] pre;
        logic [7:0] step;
        logic [18:0] pos;
        logic main;
        logic comp;
        logic fw_ok;
        logic start;
    } hbp_chan_st_t;

    hbp_chan_st_t r;
    hbp_chan_st_t n;

    function automatic logic [10:0] hbp_step_len(input logic [1:0] code);
        case (code)
            hbp_pkg::FREQ_80: hbp_step_len = hbp_pkg::STEP_A_CYC;
            hbp_pkg::FREQ_100: hbp_step_len = hbp_pkg::STEP_B_CYC;
            hbp_pkg::FREQ_200: hbp_step_len = hbp_pkg::STEP_C_CYC;
            default: hbp_step_len = 11'h001;
        endcase
    endfunction : hbp_step_len

    ////////////////////////////////////////////////////////////////////////
    // counter and shadow update; settings move at a period boundary, or at once when the code is stop
    always_comb begin
        logic [10:0] slen;
        logic [18:0] on_end;
        logic [18:0] period;
        logic last;
        n = r;
        n.start = 1'b0;
        slen = hbp_step_len(r.code);
        last = (r.step == 8'hFF) && (r.pre == slen - 11'h001);
        if (i_freq == hbp_pkg::FREQ_STOP) begin
            n.code = hbp_pkg::FREQ_STOP;
            n.duty = i_duty;
            n.pre = 11'h000;
            n.step = 8'h00;
            n.pos = 19'h00000;
        end else if (r.code == hbp_pkg::FREQ_STOP || last) begin
            n.code = i_freq;
            n.duty = i_duty;
            n.pre = 11'h000;
            n.step = 8'h00;
            n.pos = 19'h00000;
            n.start = 1'b1;
        end else begin
            n.pos = r.pos + 19'h00001;
            if (r.pre == slen - 11'h001) begin
                n.pre = 11'h000;
                n.step = r.step + 8'h01;
            end else begin
                n.pre = r.pre + 11'h001;
            end
        end
        // waveforms from the next state so they line up with the counter
        slen = hbp_step_len(n.code);
        on_end = 19'(n.duty) * 19'(slen); // on time proportional to duty
        period = {slen, 8'h00};
        if (n.code == hbp_pkg::FREQ_STOP) begin
            n.main = 1'b0;
            n.comp = 1'b0;
            n.fw_ok = 1'b0;
        end else begin
            n.main = n.pos < on_end;
            n.comp = (n.pos >= on_end + hbp_pkg::DEAD_HL_CYC) && (n.pos + hbp_pkg::DEAD_LH_CYC < period);
            // both the on time and the off time must exceed the summed dead times
            n.fw_ok = (on_end > hbp_pkg::DEAD_HL_CYC + hbp_pkg::DEAD_LH_CYC)
                && (period - on_end > hbp_pkg::DEAD_HL_CYC + hbp_pkg::DEAD_LH_CYC);
        end
    end

    // state register
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign o_main = r.main;
    assign o_comp = r.comp;
    assign o_fw_ok = r.fw_ok;
    assign o_period_start = r.start;
    assign o_running = (r.code != hbp_pkg::FREQ_STOP);

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence chan_started_s;
        ##1 (r.start && r.pos == 19'h00000);
    endsequence

    start_on_run_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (r.code == hbp_pkg::FREQ_STOP && i_freq != hbp_pkg::FREQ_STOP) |-> chan_started_s)
        else $error("period did not start after leaving stop");

    stop_holds_off_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_freq == hbp_pkg::FREQ_STOP) |=> (!o_main && !o_comp && !o_running))
        else $error("stopped channel still drives");

    shadow_steady_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (o_running && i_freq != hbp_pkg::FREQ_STOP && r.step != 8'hFF) |=> $stable(r.duty) && $stable(r.code))
        else $error("setting changed inside a period");

    no_overlap_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_comp |-> (!o_main && !$past(o_main, 1)))
        else $error("complement overlaps main drive");

endmodule : hbp_pwm_chan

// file: sim/hbp_host_model.sv
/*
 * Host model: register port master driving the block's bus.
 * Assumes one clock shared with the block and a slave that never stalls.
 */
`timescale 1ns/10ps
module hbp_host_model (
    // clock
    input wire logic i_clk_sys,
    // register port
    output logic [7:0] o_addr,
    output logic [31:0] o_wdata,
    output logic o_wr,
    output logic o_rd
);
    initial begin
        o_addr = 8'hFF;
        o_wdata = 32'hFFFFFFFF;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one-cycle strobe; idle bus shows inverted values so stale data never passes
    task automatic access(input logic [7:0] a, input logic [31:0] d, input logic w);
        @(posedge i_clk_sys);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= w;
        o_rd <= ~w;
        @(posedge i_clk_sys);
        o_wr <= 1'b0;
        o_rd <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask : access
endmodule : hbp_host_model

// file: sim/test_hbp_top.sv
/*
 * Self-checking bench for the half-bridge mode and PWM control block.
 * Assumes the host model as bus master and pins driven from here.
 */
`timescale 1ns/10ps
module test_hbp_top;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic i_wake = 1'b1;
    logic i_vdd_good = 1'b1;
    logic i_vs_good = 1'b1;
    logic [7:0] i_addr;
    logic [31:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [31:0] o_rdata;
    logic [9:0] o_hs_on;
    logic [9:0] o_ls_on;
    logic o_pump_on;
    logic o_irq;
    int n_mismatch = 0;
    int check_count = 0;
    logic [31:0] exp_q[$];
    logic rd_pend = 1'b0;
    logic [31:0] seed = 32'h0736;
    logic [10:0] steps[3] = '{hbp_pkg::STEP_A_CYC, hbp_pkg::STEP_B_CYC, hbp_pkg::STEP_C_CYC};

    always #20 i_clk_sys = ~i_clk_sys;

    hbp_top u_hbp_top (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_wake(i_wake), .i_vdd_good(i_vdd_good),
        .i_vs_good(i_vs_good), .o_hs_on(o_hs_on), .o_ls_on(o_ls_on), .o_pump_on(o_pump_on), .o_irq(o_irq));
    hbp_host_model u_hbp_host_model (.i_clk_sys(i_clk_sys), .o_addr(i_addr), .o_wdata(i_wdata),
        .o_wr(i_wr), .o_rd(i_rd));

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_hbp_host_model.access(a, d, 1'b1);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        u_hbp_host_model.access(a, 32'h00000000, 1'b0);
    endtask : rd
    task automatic pins(input logic [19:0] e);
        chk({12'h000, o_hs_on, o_ls_on}, {12'h000, e});
    endtask : pins
    // high width of bridge 0 high side; may rewrite the duty mid-pulse
    task automatic width(input logic upd, input logic [7:0] nd, output int w);
        w = 0;
        for (int i = 0; i < 12 && o_hs_on[0] !== 1'b1; i++) @(negedge i_clk_sys);
        fork
            while (o_hs_on[0] === 1'b1 && w < 20000) begin
                @(negedge i_clk_sys);
                w++;
            end
            if (upd) begin
                cyc(20);
                wr(hbp_pkg::OFS_DUTY, {24'h000000, nd});
            end
        join
    endtask : width
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////
    // read data stands only in the cycle after the strobe, so compare there
    always @(posedge i_clk_sys) begin
        if (rd_pend) begin
            chk(o_rdata, exp_q.pop_front());
        end
        rd_pend <= i_rd;
    end

    // watchdog: the tests need about 14k cycles, the longest pulse being under 10k
    initial begin
        cyc(60000);
        n_mismatch++;
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        int w;
        logic [7:0] d;
        logic [7:0] ofs[7];
        ofs = '{hbp_pkg::OFS_ACT_HS, hbp_pkg::OFS_ACT_LS, hbp_pkg::OFS_ASSIGN, hbp_pkg::OFS_FREQ,
            hbp_pkg::OFS_DUTY, hbp_pkg::OFS_FW, 8'h40};
        cyc(10);
        i_rst <= 1'b0;
        cyc(6);
        chk({31'h0, o_pump_on}, 32'h1);
        pins(20'h00000);
        rd(hbp_pkg::OFS_STATUS, 32'h6);
        for (int i = 0; i < 7; i++) rd(ofs[i], 32'h0);
        wr(hbp_pkg::OFS_STATUS, 32'h1);
        rd(hbp_pkg::OFS_STATUS, 32'h7);
        $display("test reset and defaults done");
        // continuous drive, then a load supply dropout that must not lose it
        wr(hbp_pkg::OFS_ACT_HS, 32'h1);
        wr(hbp_pkg::OFS_ACT_LS, 32'h2);
        wr(hbp_pkg::OFS_IRQ_MASK, 32'h8);
        cyc(3);
        pins({10'h001, 10'h002});
        i_vs_good <= 1'b0;
        cyc(6);
        pins(20'h00000);
        chk({31'h0, o_irq}, 32'h1);
        rd(hbp_pkg::OFS_IRQ_ST, 32'h8);
        cyc(1);
        chk({31'h0, o_irq}, 32'h0);
        i_vs_good <= 1'b1;
        cyc(6);
        pins({10'h001, 10'h002});
        rd(hbp_pkg::OFS_IRQ_ST, 32'h10);
        $display("test continuous and supply done");
        // every running code; the last one rewrites the duty mid-pulse
        for (int c = 1; c <= 3; c++) begin
            seed = xs(seed);
            d = 8'(1 + seed[2:0]);
            wr(hbp_pkg::OFS_FREQ, 32'h0);
            wr(hbp_pkg::OFS_FW, 32'h0);
            wr(hbp_pkg::OFS_ASSIGN, 32'h1);
            wr(hbp_pkg::OFS_DUTY, {24'h000000, d});
            wr(hbp_pkg::OFS_ACT_HS, 32'h1);
            wr(hbp_pkg::OFS_FREQ, 32'(c));
            width(c == 3, 8'hF0, w);
            chk(32'(w), 32'(d) * 32'(steps[c - 1]));
        end
        wr(hbp_pkg::OFS_FREQ, 32'h3);
        cyc(8);
        wr(hbp_pkg::OFS_FREQ, 32'h0);
        cyc(3);
        chk({31'h0, o_hs_on[0]}, 32'h0);
        wr(hbp_pkg::OFS_FW, 32'h1);
        cyc(3);
        chk({30'h0, o_hs_on[0], o_ls_on[0]}, 32'h1);
        $display("test pwm done");
        // sleep and logic supply loss
        i_wake <= 1'b0;
        cyc(6);
        pins(20'h00000);
        chk({31'h0, o_pump_on}, 32'h0);
        // read status in the second cycle of normal mode, so the wake-back check sees it
        i_wake <= 1'b1;
        cyc(4);
        rd(hbp_pkg::OFS_STATUS, 32'h6);
        rd(hbp_pkg::OFS_ACT_HS, 32'h0);
        i_vdd_good <= 1'b0;
        cyc(6);
        rd(hbp_pkg::OFS_STATUS, 32'h0);
        pins(20'h00000);
        i_vdd_good <= 1'b1;
        cyc(6);
        rd(hbp_pkg::OFS_STATUS, 32'h6);
        cyc(2);
        $display("test sleep and supply loss done");
        final_report();
    end
endmodule : test_hbp_top
